// ### shared/crs_defs.svh
`ifndef CRS_DEFS_SVH
`define CRS_DEFS_SVH

// ==========================================================
// register map, byte addresses
`define CRS_ADDR_W          9
`define CRS_ADDR_CUR        9'h186
`define CRS_ADDR_ISO        9'h188
`define CRS_ADDR_CFG        9'h18A
`define CRS_ADDR_CKS        9'h18C
`define CRS_ADDR_SN0        9'h18E
`define CRS_ADDR_SN1        9'h190
`define CRS_ADDR_SN2        9'h192
`define CRS_ADDR_SN3        9'h194
`define CRS_ADDR_SN4        9'h196

// ==========================================================
// word layout
`define CRS_DATA_W          16
`define CRS_NV_WORDS        3
`define CRS_SN_WORDS        5
`define CRS_SN_BITS         80
`define CRS_CKS_W           32
`define CRS_CFG_MSB         5
`define CRS_CFG_LSB         3
`define CRS_RD_IDLE         16'h0000
`define CRS_CKS_RST         32'h0000_0000

// ==========================================================
// storage indices and walk counter
`define CRS_IDX_W           2
`define CRS_IDX_CUR         2'h0
`define CRS_IDX_ISO         2'h1
`define CRS_IDX_CFG         2'h2
`define CRS_WALK_W          3
`define CRS_WALK_FIRST      3'h0
`define CRS_WALK_STEP       3'h1
`define CRS_WALK_NV_END     3'h3
`define CRS_WALK_LAST       3'h7

`endif

// ### shared/crs_pkg.sv
`include "crs_defs.svh"

package crs_pkg;
    typedef logic [`CRS_DATA_W-1:0] crs_word_t;
    typedef logic [`CRS_CKS_W-1:0]  crs_sum_t;
    typedef logic [`CRS_IDX_W-1:0]  crs_idx_t;
    typedef logic [`CRS_WALK_W-1:0] crs_walk_t;
    typedef enum logic [1:0] {
        CRS_CKS_CLEAR,
        CRS_CKS_SUM,
        CRS_CKS_DONE
    } crs_cks_state_t;
endpackage

// ### shared/crs_mem_if.sv
interface crs_mem_if;
    import crs_pkg::*;
    logic      wr_en;
    crs_idx_t  wr_idx;
    crs_word_t wr_word;
    crs_idx_t  bus_idx;
    crs_word_t bus_word;
    crs_idx_t  walk_idx;
    crs_word_t walk_word;
    modport ctrl (output wr_en, output wr_idx, output wr_word, output bus_idx,
                  output walk_idx, input bus_word, input walk_word);
    modport mem  (input wr_en, input wr_idx, input wr_word, input bus_idx,
                  input walk_idx, output bus_word, output walk_word);
endinterface

// ### src/crs_nv_array.sv
`include "crs_defs.svh"

module crs_nv_array
    import crs_pkg::*;
#(
    parameter int NWORDS = `CRS_NV_WORDS
)(
    input  wire logic clk_sys,
    input  wire logic nrst,
    input  wire logic ce,
    crs_mem_if.mem    mp
);
    // ==========================================================
    // storage
    // no reset on purpose: the record must outlive resets and sessions
    crs_word_t [NWORDS-1:0] mem;

    always_ff @(posedge clk_sys) begin
        if (ce && mp.wr_en) begin
            mem[mp.wr_idx] <= mp.wr_word;
        end
    end

    assign mp.bus_word  = mem[mp.bus_idx];
    assign mp.walk_word = mem[mp.walk_idx];

    // ==========================================================
    // checks
    AST_NO_HW_CHANGE: assert property (@(posedge clk_sys) disable iff (!nrst)
        !(ce && mp.wr_en) |=> $stable(mem))
        else $error("record word changed without a software write");

    AST_SURVIVES_RESET: assert property (@(posedge clk_sys)
        $rose(nrst) |-> $stable(mem))
        else $error("record word lost across reset");

    COV_REC_WRITE: cover property (@(posedge clk_sys) disable iff (!nrst)
        ce && mp.wr_en && mp.wr_idx == `CRS_IDX_CFG);
endmodule

// ### src/crs_top.sv
// Chosen here: the address-and-strobe port.
`include "crs_defs.svh"

module crs_top
    import crs_pkg::*;
#(
    // value is arbitrary, stands for a per-unit programmed number
    parameter logic [`CRS_SN_BITS-1:0] SERIAL_NUMBER = 80'h5A5A_1234_5678_9ABC_DEF0
)(
    input  wire logic                   clk_sys,
    input  wire logic                   nrst,
    input  wire logic                   ce,
    input  wire logic [`CRS_ADDR_W-1:0] addr,
    input  wire logic [`CRS_DATA_W-1:0] wr_data,
    input  wire logic                   wr_stb,
    input  wire logic                   rd_stb,
    output logic      [`CRS_DATA_W-1:0] rd_data,
    output logic                        cks_valid
);
    // ==========================================================
    // helpers
    function automatic crs_word_t sn_word(input logic [`CRS_WALK_W-1:0] k);
        sn_word = SERIAL_NUMBER[k*`CRS_DATA_W +: `CRS_DATA_W];
    endfunction

    function automatic logic is_nv_addr(input logic [`CRS_ADDR_W-1:0] a);
        is_nv_addr = (a == `CRS_ADDR_CUR) || (a == `CRS_ADDR_ISO) ||
                     (a == `CRS_ADDR_CFG);
    endfunction

    function automatic crs_idx_t nv_index(input logic [`CRS_ADDR_W-1:0] a);
        case (a)
            `CRS_ADDR_ISO: nv_index = `CRS_IDX_ISO;
            `CRS_ADDR_CFG: nv_index = `CRS_IDX_CFG;
            default:       nv_index = `CRS_IDX_CUR;
        endcase
    endfunction

    // ==========================================================
    // storage
    crs_mem_if mif ();

    crs_nv_array #(
        .NWORDS (`CRS_NV_WORDS)
    ) i_crs_nv_array (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .ce      (ce),
        .mp      (mif.mem)
    );

    logic wr_hit;
    assign wr_hit = wr_stb && is_nv_addr(addr);

    // whole words are kept, so undefined bits of the configuration word
    // simply read back what software wrote
    assign mif.wr_en   = wr_hit;
    assign mif.wr_idx  = nv_index(addr);
    assign mif.wr_word = wr_data;
    assign mif.bus_idx = nv_index(addr);

    // ==========================================================
    // checksum walk
    crs_cks_state_t state;
    crs_walk_t      walk;
    crs_sum_t       acc;
    crs_sum_t       cks_sum;
    crs_word_t      walk_val;

    // keep the array index in range once the walk has moved on to the serial words
    assign mif.walk_idx = (walk < `CRS_WALK_NV_END) ? walk[`CRS_IDX_W-1:0]
                                                     : `CRS_IDX_CUR;
    assign walk_val = (walk < `CRS_WALK_NV_END) ? mif.walk_word
                                                : sn_word(walk - `CRS_WALK_NV_END);

    // a write to a record word restarts the walk so the sum never mixes old and new words;
    // the last completed sum stays visible while a new one is built
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state <= CRS_CKS_CLEAR;
            walk  <= `CRS_WALK_FIRST;
            acc   <= `CRS_CKS_RST;
        end else if (ce) begin
            if (wr_hit) begin
                state <= CRS_CKS_CLEAR;
                walk  <= `CRS_WALK_FIRST;
                acc   <= `CRS_CKS_RST;
            end else begin
                case (state)
                    CRS_CKS_CLEAR: begin
                        state <= CRS_CKS_SUM;
                        walk  <= `CRS_WALK_FIRST;
                        acc   <= `CRS_CKS_RST;
                    end
                    CRS_CKS_SUM: begin
                        acc <= acc + {{(`CRS_CKS_W-`CRS_DATA_W){1'h0}}, walk_val};
                        if (walk == `CRS_WALK_LAST) begin
                            state <= CRS_CKS_DONE;
                        end else begin
                            walk <= walk + `CRS_WALK_STEP;
                        end
                    end
                    CRS_CKS_DONE: begin
                        state <= CRS_CKS_DONE;
                    end
                    default: begin
                        state <= CRS_CKS_CLEAR;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cks_sum <= `CRS_CKS_RST;
        end else if (ce && !wr_hit && state == CRS_CKS_SUM && walk == `CRS_WALK_LAST) begin
            cks_sum <= acc + {{(`CRS_CKS_W-`CRS_DATA_W){1'h0}}, walk_val};
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cks_valid <= 1'h0;
        end else if (ce) begin
            if (wr_hit) begin
                cks_valid <= 1'h0;
            end else if (state == CRS_CKS_SUM && walk == `CRS_WALK_LAST) begin
                cks_valid <= 1'h1;
            end
        end
    end

    // ==========================================================
    // read port
    logic [`CRS_DATA_W-1:0] next_rd_data;

    always_comb begin
        next_rd_data = `CRS_RD_IDLE;
        if (rd_stb) begin
            case (addr)
                `CRS_ADDR_CUR: next_rd_data = mif.bus_word;
                `CRS_ADDR_ISO: next_rd_data = mif.bus_word;
                `CRS_ADDR_CFG: next_rd_data = mif.bus_word;
                `CRS_ADDR_CKS: next_rd_data = cks_sum[`CRS_DATA_W-1:0];
                `CRS_ADDR_SN0: next_rd_data = sn_word(3'h0);
                `CRS_ADDR_SN1: next_rd_data = sn_word(3'h1);
                `CRS_ADDR_SN2: next_rd_data = sn_word(3'h2);
                `CRS_ADDR_SN3: next_rd_data = sn_word(3'h3);
                `CRS_ADDR_SN4: next_rd_data = sn_word(3'h4);
                default:       next_rd_data = `CRS_RD_IDLE;
            endcase
        end
    end

    // data stand in the cycle after a strobe taken with ce high, zero after other enabled cycles; ce low holds rd_data
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rd_data <= `CRS_RD_IDLE;
        end else if (ce) begin
            rd_data <= next_rd_data;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    AST_CUR_READBACK: assert property (
        ce && wr_stb && addr == `CRS_ADDR_CUR ##1
        ce && rd_stb && addr == `CRS_ADDR_CUR
        |=> rd_data == $past(wr_data, 2))
        else $error("current status word did not read back");

    AST_ISO_READBACK: assert property (
        ce && wr_stb && addr == `CRS_ADDR_ISO ##1
        ce && rd_stb && addr == `CRS_ADDR_ISO
        |=> rd_data == $past(wr_data, 2))
        else $error("isolation word did not read back");

    AST_CFG_FIELD: assert property (
        ce && wr_stb && addr == `CRS_ADDR_CFG ##1
        ce && rd_stb && addr == `CRS_ADDR_CFG
        |=> rd_data[`CRS_CFG_MSB:`CRS_CFG_LSB] ==
            $past(wr_data[`CRS_CFG_MSB:`CRS_CFG_LSB], 2))
        else $error("configuration field did not read back");

    AST_CKS_READ: assert property (
        ce && rd_stb && addr == `CRS_ADDR_CKS
        |=> rd_data == $past(cks_sum[`CRS_DATA_W-1:0]))
        else $error("checksum read is not the low half of the sum");

    AST_CKS_FINISH: assert property (
        ce && !wr_hit && state == CRS_CKS_SUM && walk == `CRS_WALK_LAST
        |=> cks_valid && state == CRS_CKS_DONE &&
            cks_sum == $past(acc) + $past({{(`CRS_CKS_W-`CRS_DATA_W){1'h0}}, walk_val}))
        else $error("checksum walk ended with a wrong sum");

    AST_SN_LOW: assert property (
        ce && rd_stb && addr == `CRS_ADDR_SN0
        |=> rd_data == SERIAL_NUMBER[`CRS_DATA_W-1:0])
        else $error("serial word 0 is not the lowest two bytes");

    AST_SN_HIGH: assert property (
        ce && rd_stb && addr == `CRS_ADDR_SN4
        |=> rd_data == SERIAL_NUMBER[`CRS_SN_BITS-1:`CRS_SN_BITS-`CRS_DATA_W])
        else $error("serial word 4 does not hold the top bytes");

    AST_WRITE_REARMS: assert property (
        ce && wr_hit |=> !cks_valid && state == CRS_CKS_CLEAR &&
            walk == `CRS_WALK_FIRST && acc == `CRS_CKS_RST)
        else $error("write did not restart the checksum walk");

    AST_CFG_WORD: assert property (
        ce && wr_stb && addr == `CRS_ADDR_CFG ##1
        ce && rd_stb && addr == `CRS_ADDR_CFG
        |=> rd_data == $past(wr_data, 2))
        else $error("configuration word did not read back whole");

    // nothing but a software write may move a record word between two reads
    AST_CUR_STEADY: assert property (
        ce && rd_stb && !wr_stb && addr == `CRS_ADDR_CUR ##1 !(ce && wr_hit) ##1
        ce && rd_stb && addr == `CRS_ADDR_CUR
        |=> rd_data == $past(rd_data, 2))
        else $error("current status word changed between two reads");

    AST_SN_W1: assert property (
        ce && rd_stb && addr == `CRS_ADDR_SN1
        |=> rd_data == SERIAL_NUMBER[`CRS_DATA_W*2-1:`CRS_DATA_W])
        else $error("serial word 1 holds the wrong bytes");

    AST_SN_W2: assert property (
        ce && rd_stb && addr == `CRS_ADDR_SN2
        |=> rd_data == SERIAL_NUMBER[`CRS_DATA_W*3-1:`CRS_DATA_W*2])
        else $error("serial word 2 holds the wrong bytes");

    AST_SN_W3: assert property (
        ce && rd_stb && addr == `CRS_ADDR_SN3
        |=> rd_data == SERIAL_NUMBER[`CRS_DATA_W*4-1:`CRS_DATA_W*3])
        else $error("serial word 3 holds the wrong bytes");

    AST_UNMAPPED_ZERO: assert property (
        ce && rd_stb && (addr < `CRS_ADDR_CUR || addr > `CRS_ADDR_SN4)
        |=> rd_data == `CRS_RD_IDLE)
        else $error("unmapped read returned data");

    AST_RO_WRITE_KEEPS_SUM: assert property (
        ce && wr_stb && !is_nv_addr(addr) && state == CRS_CKS_DONE
        |=> cks_valid && $stable(cks_sum))
        else $error("write to a read-only word disturbed the checksum");

    AST_CE_FREEZE: assert property (
        !ce |=> $stable(rd_data) && $stable(cks_valid) && $stable(state) &&
            $stable(walk) && $stable(acc) && $stable(cks_sum))
        else $error("state moved while the clock enable was low");

    // ==========================================================
    // checksum walk checks, one per step so a broken sum points at its cycle, then the idle read-data check
    AST_WALK_START: assert property (
        ce && !wr_hit && state == CRS_CKS_CLEAR
        |=> state == CRS_CKS_SUM && walk == `CRS_WALK_FIRST && acc == `CRS_CKS_RST)
        else $error("checksum walk did not start from a clear sum");

    AST_WALK_STEP: assert property (
        ce && !wr_hit && state == CRS_CKS_SUM && walk != `CRS_WALK_LAST
        |=> state == CRS_CKS_SUM && walk == $past(walk) + `CRS_WALK_STEP)
        else $error("checksum walk skipped or repeated a word");

    AST_DONE_HOLDS: assert property (
        ce && !wr_hit && state == CRS_CKS_DONE
        |=> state == CRS_CKS_DONE && cks_valid)
        else $error("finished checksum lost its valid state");

    AST_VALID_MEANS_DONE: assert property (
        cks_valid == (state == CRS_CKS_DONE))
        else $error("checksum valid flag disagrees with the walk");

    AST_CKS_HOLD: assert property (
        !(ce && !wr_hit && state == CRS_CKS_SUM && walk == `CRS_WALK_LAST)
        |=> $stable(cks_sum))
        else $error("checksum register moved before the walk ended");

    AST_RD_ONE_CYCLE: assert property (
        ce && !rd_stb |=> rd_data == `CRS_RD_IDLE)
        else $error("read data outside the answer cycle");

    COV_CUR_RW: cover property (
        ce && wr_stb && addr == `CRS_ADDR_CUR ##1 ce && rd_stb && addr == `CRS_ADDR_CUR);
    COV_CKS_DONE: cover property ($rose(cks_valid));
    COV_SN_READ: cover property (ce && rd_stb && addr == `CRS_ADDR_SN4);
    COV_WR_DURING_WALK: cover property (state == CRS_CKS_SUM && ce && wr_hit);
endmodule

// ### testbench/crs_tb_top.sv
`include "crs_defs.svh"

module crs_tb_top
    import crs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================
    // stimulus and design
    // value is arbitrary, a made-up unit number
    localparam logic [`CRS_SN_BITS-1:0] SN = 80'h0123_4567_89AB_CDEF_1357;

    logic                   clk_sys;
    logic                   nrst;
    logic                   ce;
    logic [`CRS_ADDR_W-1:0] addr;
    crs_word_t              wr_data;
    logic                   wr_stb;
    logic                   rd_stb;
    crs_word_t              rd_data;
    logic                   cks_valid;
    int                     mismatches;
    int                     cmp_count;
    int                     cyc;
    crs_word_t              cur_v;
    crs_word_t              iso_v;
    crs_word_t              cfg_v;

    crs_top #(.SERIAL_NUMBER(SN)) i_crs_top (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .ce        (ce),
        .addr      (addr),
        .wr_data   (wr_data),
        .wr_stb    (wr_stb),
        .rd_stb    (rd_stb),
        .rd_data   (rd_data),
        .cks_valid (cks_valid)
    );

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // ==========================================
    // shared tasks
    task automatic chk(input crs_word_t got, input crs_word_t exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one bus cycle, driven just after the edge and taken at the next one
    task automatic op(input logic w, input logic r, input logic [8:0] a, input crs_word_t d);
        @(posedge clk_sys);
        addr    <= a;
        wr_data <= d;
        wr_stb  <= w;
        rd_stb  <= r;
    endtask

    task automatic rd(input logic [8:0] a, input crs_word_t exp);
        op(1'b0, 1'b1, a, 16'h0000);
        op(1'b0, 1'b0, 9'h000, 16'h0000);
        #1 chk(rd_data, exp);
    endtask

    // write directly followed by a read of the same word
    task automatic wr_rd(input logic [8:0] a, input crs_word_t d);
        op(1'b1, 1'b0, a, d);
        rd(a, d);
    endtask

    task automatic wait_cks(output int n);
        n = 0;
        while (cks_valid !== 1'b1 && n < 40) begin
            @(posedge clk_sys);
            #1 n++;
        end
    endtask

    function automatic crs_word_t exp_cks();
        crs_sum_t s;
        s = crs_sum_t'(cur_v) + crs_sum_t'(iso_v) + crs_sum_t'(cfg_v);
        for (int k = 0; k < 5; k++) s += crs_sum_t'(SN[16*k +: 16]);
        return s[15:0];
    endfunction

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ==========================================
    // scenarios
    task automatic t_store();
        cur_v = 16'hA5C3;
        iso_v = 16'h8001;
        wr_rd(`CRS_ADDR_CUR, cur_v);
        wr_rd(`CRS_ADDR_ISO, iso_v);
        wr_rd(`CRS_ADDR_CFG, 16'h0038);
        cfg_v = 16'h0000;
        wr_rd(`CRS_ADDR_CFG, cfg_v);
        rd(`CRS_ADDR_CUR, cur_v);
        rd(`CRS_ADDR_CUR, cur_v);
        $display("test store done");
    endtask

    task automatic t_ro();
        for (int k = 0; k < 5; k++) begin
            op(1'b1, 1'b0, 9'(`CRS_ADDR_SN0 + 2 * k), 16'hFFFF);
            rd(9'(`CRS_ADDR_SN0 + 2 * k), SN[16*k +: 16]);
        end
        @(posedge clk_sys);
        #1 chk(rd_data, 16'h0000);
        rd(9'h198, 16'h0000);
        rd(9'h000, 16'h0000);
        $display("test read-only done");
    endtask

    task automatic t_cks();
        int n;
        cur_v = 16'hFEDC;
        op(1'b1, 1'b0, `CRS_ADDR_CUR, cur_v);
        op(1'b0, 1'b0, 9'h000, 16'h0000);
        #1 chk({15'h0000, cks_valid}, 16'h0000);
        wait_cks(n);
        chk(16'(n), 16'h0009);
        rd(`CRS_ADDR_CKS, exp_cks());
        op(1'b1, 1'b0, `CRS_ADDR_CKS, 16'hFFFF);
        rd(`CRS_ADDR_CKS, exp_cks());
        $display("test checksum done");
    endtask

    task automatic t_ce();
        @(posedge clk_sys);
        ce <= 1'b0;
        op(1'b1, 1'b0, `CRS_ADDR_ISO, 16'h0F0F);
        op(1'b0, 1'b0, 9'h000, 16'h0000);
        ce <= 1'b1;
        rd(`CRS_ADDR_ISO, iso_v);
        $display("test enable done");
    endtask

    // reset in mid-run must not touch the record
    task automatic t_rst();
        int n;
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 chk(rd_data, 16'h0000);
        chk({15'h0000, cks_valid}, 16'h0000);
        @(posedge clk_sys);
        nrst <= 1'b1;
        rd(`CRS_ADDR_CUR, cur_v);
        rd(`CRS_ADDR_ISO, iso_v);
        rd(`CRS_ADDR_CFG, cfg_v);
        wait_cks(n);
        rd(`CRS_ADDR_CKS, exp_cks());
        rd(`CRS_ADDR_SN4, SN[79:64]);
        $display("test reset done");
    endtask

    // ==========================================
    // main sequence and hang guard
    initial begin
        nrst       = 1'b0;
        ce         = 1'b1;
        addr       = 9'h000;
        wr_data    = 16'h0000;
        wr_stb     = 1'b0;
        rd_stb     = 1'b0;
        mismatches = 0;
        cmp_count  = 0;
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        t_store();
        t_ro();
        t_cks();
        t_ce();
        t_rst();
        end_sim();
    end

    // whole run needs under a hundred cycles
    initial cyc = 0;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            end_sim();
        end
    end
endmodule
